// File: verilog/fcdma_pkg.sv
package fcdma_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_GCTRL    = 8'h00;
  localparam logic [7:0] ADDR_INTSTAT  = 8'h04;
  localparam logic [7:0] ADDR_CH_BASE  = 8'h10;
  localparam logic [7:0] CH_STRIDE     = 8'h20;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ADDRCTL   = 8'h04;
  localparam logic [7:0] OFS_TRIG      = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0C;
  localparam logic [7:0] OFS_REPEAT    = 8'h10;
  localparam logic [7:0] OFS_SRC       = 8'h14;
  localparam logic [7:0] OFS_DST       = 8'h18;
  // global control fields
  localparam int GC_ENABLE  = 0;
  localparam int GC_PRI_LSB = 1;
  localparam int GC_DBUF01  = 3;
  localparam int GC_DBUF23  = 4;
  // channel control fields
  localparam int CC_ENABLE  = 0;
  localparam int CC_REQ     = 1;
  localparam int CC_SINGLE  = 2;
  localparam int CC_REPEAT  = 3;
  localparam int CC_IE      = 4;
  localparam int CC_BL_LSB  = 5;
  localparam int CC_BUSY    = 8;
  // address control fields
  localparam int AC_SDIR_LSB = 0;
  localparam int AC_SREL_LSB = 2;
  localparam int AC_DDIR_LSB = 4;
  localparam int AC_DREL_LSB = 6;
  // interrupt status: complete flags low nibble, error flags next
  localparam int IS_ERR_LSB = 4;
  // encodings
  localparam logic [1:0] BL_ONE   = 2'h0;
  localparam logic [1:0] BL_TWO   = 2'h1;
  localparam logic [1:0] BL_FOUR  = 2'h2;
  localparam logic [1:0] BL_EIGHT = 2'h3;
  localparam logic [1:0] DIR_FIX  = 2'h0;
  localparam logic [1:0] DIR_INC  = 2'h1;
  localparam logic [1:0] DIR_DEC  = 2'h2;
  localparam logic [1:0] REL_NONE = 2'h0;
  localparam logic [1:0] REL_BLK  = 2'h1;
  localparam logic [1:0] REL_BRST = 2'h2;
  localparam logic [1:0] REL_TXN  = 2'h3;
  localparam logic [7:0] TRIG_MANUAL = 8'h00;
  localparam logic [1:0] PRI_RR     = 2'h0;
  localparam logic [1:0] PRI_C0     = 2'h1;
  localparam logic [1:0] PRI_C01    = 2'h2;
  localparam logic [1:0] PRI_FIXED  = 2'h3;

  typedef struct packed {
    logic [15:0] addr;
    logic        read;
    logic        write;
    logic [7:0]  wdata;
  } fcdma_mem_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} fcdma_state_t;
endpackage

// File: verilog/fcdma_top.sv
`timescale 1ns/100ps
// Overview of operation
// (R1) burst code selects 1, 2, 4, 8 bytes
// (R2) direction 0x01 increments address per byte
// (R3) direction 0x00 keeps address fixed
// (R4) trigger source 0x00 means manual only
// (R5) block count gives bytes directly
// (R6) source reload 0x02 restores per burst
// (R7) module enable activates controller, default priority
// (R8) channel also needs its own enable
// (R9) request bit write triggers channel
// (R10) single shot moves one burst per trigger
// (R11) completion sets flag; write one clears
// (R12) peripheral trigger starts transfers without software
// (R13) chained pair hands over on finish
// (R14) chaining only pairs 0-1 and 2-3
// (R15) pairs chain or run independently
// (R16) software gives chained pair equal repeats
// (R17) four selectable arbitration schemes
// (R18) round robin rotates per bus acquisition
// (R19) fixed priority beats round robin
// (R20) started burst never preempted
// (R21) one burst per bus acquisition
// (R22) block count zero means 65536 bytes
// (R23) repeat: complete after last block
// (R24) disable mid transaction aborts, sets error
// (R25) reload per burst, block, transaction, never
// (R26) trigger while waiting held pending
// (R27) block ends at exact byte count
// (R28) complete flag sticky, gated interrupt request
module fcdma_top (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  // register port
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_write_in,
  input  wire logic                    reg_read_in,
  output logic      [31:0]             reg_rdata_out,
  // peripheral trigger events, one bit per source number
  input  wire logic [255:0]            periph_trig_in,
  // system data bus
  output fcdma_pkg::fcdma_mem_req_t    mem_req_out,
  input  wire logic [7:0]              mem_rdata_in,
  input  wire logic                    mem_ready_in,
  // interrupt requests per channel
  output logic      [3:0]              chan_irq_out
);
  localparam int NCH = 4;

  logic [7:0]  gctrl_reg;
  logic [3:0]  done_flag_reg;
  logic [3:0]  err_flag_reg;
  logic [7:0]  cctrl_reg   [NCH];
  logic [7:0]  actl_reg    [NCH];
  logic [7:0]  trig_reg    [NCH];
  logic [15:0] count_reg   [NCH];
  logic [7:0]  rep_reg     [NCH];
  logic [15:0] src_reg     [NCH];
  logic [15:0] dst_reg     [NCH];
  logic [15:0] src_cur_reg [NCH];
  logic [15:0] dst_cur_reg [NCH];
  logic [16:0] left_reg    [NCH];
  logic [7:0]  rep_left_reg[NCH];
  logic [3:0]  busy_reg;
  logic [3:0]  pend_reg;
  logic [3:0]  armed_reg;

  fcdma_pkg::fcdma_state_t state_reg;
  logic [1:0]  cur_reg;
  logic [3:0]  burst_left_reg;
  logic [7:0]  data_reg;
  logic [1:0]  rr_reg;

  logic        mod_en;
  logic [1:0]  pri;
  logic [3:0]  ch_sel;
  logic [3:0]  ch_wr;
  logic [3:0]  ready_ch;
  logic [3:0]  trig_ev;
  logic [3:0]  abort_ch;
  logic [3:0]  finish_ch;
  logic        is_reg_ch;
  logic [1:0]  reg_ch;
  logic [7:0]  reg_ofs;
  logic        grant_v;
  logic [1:0]  grant_ch;
  logic        byte_done;
  logic        burst_end;
  logic        block_end;
  logic        txn_end;
  logic        last_block;

  assign mod_en    = gctrl_reg[fcdma_pkg::GC_ENABLE]; // R7
  assign pri       = gctrl_reg[fcdma_pkg::GC_PRI_LSB +: 2];
  assign is_reg_ch = (reg_addr_in >= fcdma_pkg::ADDR_CH_BASE) &&
                     (reg_addr_in < 8'h90);
  assign reg_ch    = 2'((reg_addr_in - fcdma_pkg::ADDR_CH_BASE) >> 5);
  assign reg_ofs   = (reg_addr_in - fcdma_pkg::ADDR_CH_BASE) & 8'h1F;

  // per channel decode, triggers and status
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ch_sel[g] = is_reg_ch && (reg_ch == 2'(g));
      assign ch_wr[g]  = reg_write_in && ch_sel[g] && (reg_ofs == fcdma_pkg::OFS_CTRL);
      assign trig_ev[g] = (ch_wr[g] && reg_wdata_in[fcdma_pkg::CC_REQ]) || // R9
                          ((trig_reg[g] != fcdma_pkg::TRIG_MANUAL) &&
                           periph_trig_in[trig_reg[g]]); // R4 R12
      assign abort_ch[g] = busy_reg[g] &&
                           (!mod_en || !cctrl_reg[g][fcdma_pkg::CC_ENABLE]); // R24
      assign ready_ch[g] = mod_en && cctrl_reg[g][fcdma_pkg::CC_ENABLE] &&
                           pend_reg[g] && armed_reg[g]; // R8
      assign finish_ch[g] = txn_end && (cur_reg == 2'(g));
    end
  endgenerate

  // arbitration: fixed channels first, then rotating pointer; fixed mode takes 2 before 3 with no pointer
  always_comb begin
    logic [1:0] c;
    logic [2:0] k;
    c = 2'h0;
    k = 3'h0;
    grant_v  = 1'b0;
    grant_ch = 2'h0;
    if (pri != fcdma_pkg::PRI_RR && ready_ch[0]) begin // R17 R19
      grant_v  = 1'b1;
      grant_ch = 2'h0;
    end else if ((pri == fcdma_pkg::PRI_C01 || pri == fcdma_pkg::PRI_FIXED) &&
                 ready_ch[1]) begin
      grant_v  = 1'b1;
      grant_ch = 2'h1;
    end else if (pri == fcdma_pkg::PRI_FIXED) begin
      if (ready_ch[2]) begin
        grant_v  = 1'b1;
        grant_ch = 2'h2;
      end else if (ready_ch[3]) begin
        grant_v  = 1'b1;
        grant_ch = 2'h3;
      end
    end else begin
      for (k = 3'h0; k < 3'h4; k++) begin // R18
        c = rr_reg + k[1:0];
        if (!grant_v && ready_ch[c]) begin
          grant_v  = 1'b1;
          grant_ch = c;
        end
      end
    end
  end

  assign byte_done  = (state_reg == fcdma_pkg::ST_WRITE) && mem_ready_in;
  assign block_end  = byte_done && (left_reg[cur_reg] == 17'h1); // R27
  assign burst_end  = byte_done && ((burst_left_reg == 4'h1) || block_end);
  assign last_block = !cctrl_reg[cur_reg][fcdma_pkg::CC_REPEAT] ||
                      (rep_left_reg[cur_reg] == 8'h01 && |rep_reg[cur_reg]);
  assign txn_end    = block_end && last_block;

  // bus engine, one burst per acquisition
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg      <= fcdma_pkg::ST_IDLE;
      cur_reg        <= 2'h0;
      burst_left_reg <= 4'h0;
      data_reg       <= 8'h00;
      rr_reg         <= 2'h0;
    end else begin
      case (state_reg)
        fcdma_pkg::ST_IDLE: begin
          if (grant_v) begin // R21
            state_reg <= fcdma_pkg::ST_READ;
            cur_reg   <= grant_ch;
            rr_reg    <= grant_ch + 2'h1;
            case (cctrl_reg[grant_ch][fcdma_pkg::CC_BL_LSB +: 2]) // R1
              fcdma_pkg::BL_ONE:   burst_left_reg <= 4'h1;
              fcdma_pkg::BL_TWO:   burst_left_reg <= 4'h2;
              fcdma_pkg::BL_FOUR:  burst_left_reg <= 4'h4;
              default:             burst_left_reg <= 4'h8;
            endcase
          end
        end
        fcdma_pkg::ST_READ: begin
          if (abort_ch[cur_reg]) begin
            state_reg <= fcdma_pkg::ST_IDLE;
          end else if (mem_ready_in) begin
            data_reg  <= mem_rdata_in;
            state_reg <= fcdma_pkg::ST_WRITE;
          end
        end
        fcdma_pkg::ST_WRITE: begin
          if (abort_ch[cur_reg]) begin
            state_reg <= fcdma_pkg::ST_IDLE;
          end else if (mem_ready_in) begin
            burst_left_reg <= burst_left_reg - 4'h1;
            state_reg <= burst_end ? fcdma_pkg::ST_IDLE : fcdma_pkg::ST_READ; // R20
          end
        end
        default: state_reg <= fcdma_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    mem_req_out       = '0;
    mem_req_out.addr  = src_cur_reg[cur_reg];
    mem_req_out.wdata = data_reg;
    if (state_reg == fcdma_pkg::ST_READ) begin
      mem_req_out.read = 1'b1;
    end else if (state_reg == fcdma_pkg::ST_WRITE) begin
      mem_req_out.write = 1'b1;
      mem_req_out.addr  = dst_cur_reg[cur_reg];
    end
  end

  // per channel state: registers, pointers, counters
  generate
    for (g = 0; g < NCH; g++) begin : g_state
      logic mine;
      logic [1:0] sdir, ddir, srel, drel;
      logic chain_in;
      assign mine = (cur_reg == 2'(g)) && (state_reg != fcdma_pkg::ST_IDLE);
      assign sdir = actl_reg[g][fcdma_pkg::AC_SDIR_LSB +: 2];
      assign srel = actl_reg[g][fcdma_pkg::AC_SREL_LSB +: 2];
      assign ddir = actl_reg[g][fcdma_pkg::AC_DDIR_LSB +: 2];
      assign drel = actl_reg[g][fcdma_pkg::AC_DREL_LSB +: 2];
      // partner finishing re-arms this channel
      assign chain_in = gctrl_reg[(g < 2) ? fcdma_pkg::GC_DBUF01 : fcdma_pkg::GC_DBUF23] &&
                        finish_ch[g ^ 1]; // R13 R14 R15

      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cctrl_reg[g] <= 8'h00;
          actl_reg[g]  <= 8'h00;
          trig_reg[g]  <= 8'h00;
          count_reg[g] <= 16'h0000;
          rep_reg[g]   <= 8'h00;
          src_reg[g]   <= 16'h0000;
          dst_reg[g]   <= 16'h0000;
        end else if (reg_write_in && ch_sel[g]) begin
          case (reg_ofs)
            fcdma_pkg::OFS_CTRL:    cctrl_reg[g] <= reg_wdata_in[7:0] &
                                                    ~(8'h01 << fcdma_pkg::CC_REQ);
            fcdma_pkg::OFS_ADDRCTL: actl_reg[g]  <= reg_wdata_in[7:0];
            fcdma_pkg::OFS_TRIG:    trig_reg[g]  <= reg_wdata_in[7:0];
            fcdma_pkg::OFS_COUNT:   count_reg[g] <= reg_wdata_in[15:0];
            fcdma_pkg::OFS_REPEAT:  rep_reg[g]   <= reg_wdata_in[7:0];
            fcdma_pkg::OFS_SRC:     src_reg[g]   <= reg_wdata_in[15:0];
            fcdma_pkg::OFS_DST:     dst_reg[g]   <= reg_wdata_in[15:0];
            default: ;
          endcase
        end
      end

      // pending trigger and transaction progress
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          pend_reg[g]     <= 1'b0;
          busy_reg[g]     <= 1'b0;
          armed_reg[g]    <= 1'b1;
          left_reg[g]     <= 17'h00000;
          rep_left_reg[g] <= 8'h00;
          src_cur_reg[g]  <= 16'h0000;
          dst_cur_reg[g]  <= 16'h0000;
        end else if (abort_ch[g] || !cctrl_reg[g][fcdma_pkg::CC_ENABLE]) begin
          busy_reg[g]  <= 1'b0; // R24
          pend_reg[g]  <= 1'b0;
          armed_reg[g] <= 1'b1;
        end else begin
          if (chain_in) begin
            armed_reg[g] <= 1'b1;
          end else if (finish_ch[g] && gctrl_reg[(g < 2) ? fcdma_pkg::GC_DBUF01 :
                                                 fcdma_pkg::GC_DBUF23]) begin
            armed_reg[g] <= 1'b0;
          end
          if (!busy_reg[g] && trig_ev[g]) begin
            busy_reg[g]     <= 1'b1;
            left_reg[g]     <= (count_reg[g] == 16'h0000) ? 17'h10000 :
                               {1'b0, count_reg[g]}; // R5 R22
            rep_left_reg[g] <= rep_reg[g];
            src_cur_reg[g]  <= src_reg[g];
            dst_cur_reg[g]  <= dst_reg[g];
          end
          // set wins over the grant clear
          if (trig_ev[g]) begin
            pend_reg[g] <= 1'b1; // R26
          end else if (mine && state_reg == fcdma_pkg::ST_IDLE) begin
            pend_reg[g] <= pend_reg[g];
          end else if (grant_v && grant_ch == 2'(g) && state_reg == fcdma_pkg::ST_IDLE) begin
            pend_reg[g] <= cctrl_reg[g][fcdma_pkg::CC_SINGLE] ? 1'b0 : 1'b1; // R10
          end else if (byte_done && mine && block_end) begin
            pend_reg[g] <= 1'b0;
          end
          if (byte_done && mine) begin
            left_reg[g] <= block_end ? ((count_reg[g] == 16'h0000) ? 17'h10000 :
                                        {1'b0, count_reg[g]}) : left_reg[g] - 17'h1;
            if (block_end) begin
              rep_left_reg[g] <= rep_left_reg[g] - 8'h01;
            end
            if (txn_end) begin
              busy_reg[g] <= 1'b0;
            end
            // address stepping and reload
            if ((srel == fcdma_pkg::REL_BRST && burst_end) || // R6 R25
                (srel == fcdma_pkg::REL_BLK && block_end) ||
                (srel == fcdma_pkg::REL_TXN && txn_end)) begin
              src_cur_reg[g] <= src_reg[g];
            end else if (sdir == fcdma_pkg::DIR_INC) begin
              src_cur_reg[g] <= src_cur_reg[g] + 16'h0001; // R2
            end else if (sdir == fcdma_pkg::DIR_DEC) begin
              src_cur_reg[g] <= src_cur_reg[g] - 16'h0001;
            end // R3
            if ((drel == fcdma_pkg::REL_BRST && burst_end) || // R25
                (drel == fcdma_pkg::REL_BLK && block_end) ||
                (drel == fcdma_pkg::REL_TXN && txn_end)) begin
              dst_cur_reg[g] <= dst_reg[g];
            end else if (ddir == fcdma_pkg::DIR_INC) begin
              dst_cur_reg[g] <= dst_cur_reg[g] + 16'h0001; // R2
            end else if (ddir == fcdma_pkg::DIR_DEC) begin
              dst_cur_reg[g] <= dst_cur_reg[g] - 16'h0001;
            end // R3
          end
        end
      end

      // sticky flags, set wins over write-one clear
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          done_flag_reg[g] <= 1'b0;
          err_flag_reg[g]  <= 1'b0;
        end else begin
          if ((byte_done && mine && block_end &&
               (last_block || (cctrl_reg[g][fcdma_pkg::CC_REPEAT] &&
                               rep_reg[g] == 8'h00)))) begin
            done_flag_reg[g] <= 1'b1; // R11 R23 R28
          end else if (reg_write_in && reg_addr_in == fcdma_pkg::ADDR_INTSTAT &&
                       reg_wdata_in[g]) begin
            done_flag_reg[g] <= 1'b0; // R11
          end
          if (abort_ch[g]) begin
            err_flag_reg[g] <= 1'b1; // R24
          end else if (reg_write_in && reg_addr_in == fcdma_pkg::ADDR_INTSTAT &&
                       reg_wdata_in[fcdma_pkg::IS_ERR_LSB + g]) begin
            err_flag_reg[g] <= 1'b0;
          end
        end
      end

      assign chan_irq_out[g] = cctrl_reg[g][fcdma_pkg::CC_IE] &&
                               (done_flag_reg[g] || err_flag_reg[g]); // R28
    end
  endgenerate

  // global control
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gctrl_reg <= 8'h00;
    end else if (reg_write_in && reg_addr_in == fcdma_pkg::ADDR_GCTRL) begin
      gctrl_reg <= reg_wdata_in[7:0];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_read_in) begin
      reg_rdata_out <= 32'h00000000;
      if (reg_addr_in == fcdma_pkg::ADDR_GCTRL) begin
        reg_rdata_out <= {24'h000000, gctrl_reg};
      end else if (reg_addr_in == fcdma_pkg::ADDR_INTSTAT) begin
        reg_rdata_out <= {24'h000000, err_flag_reg, done_flag_reg};
      end else if (is_reg_ch) begin
        case (reg_ofs)
          fcdma_pkg::OFS_CTRL:    reg_rdata_out <= {23'h000000, busy_reg[reg_ch],
                                                    cctrl_reg[reg_ch]};
          fcdma_pkg::OFS_ADDRCTL: reg_rdata_out <= {24'h000000, actl_reg[reg_ch]};
          fcdma_pkg::OFS_TRIG:    reg_rdata_out <= {24'h000000, trig_reg[reg_ch]};
          fcdma_pkg::OFS_COUNT:   reg_rdata_out <= {16'h0000, count_reg[reg_ch]};
          fcdma_pkg::OFS_REPEAT:  reg_rdata_out <= {24'h000000, rep_reg[reg_ch]};
          fcdma_pkg::OFS_SRC:     reg_rdata_out <= {16'h0000, src_reg[reg_ch]};
          fcdma_pkg::OFS_DST:     reg_rdata_out <= {16'h0000, dst_reg[reg_ch]};
          default:                reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: tb/fcdma_top_assertions.sv
`timescale 1ns/100ps
module fcdma_top_checker (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  // register port
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic [31:0]               reg_wdata_in,
  input  wire logic                      reg_write_in,
  input  wire logic                      reg_read_in,
  input  wire logic [31:0]               reg_rdata_out,
  // system data bus
  input  wire fcdma_pkg::fcdma_mem_req_t mem_req_out,
  input  wire logic [7:0]                mem_rdata_in,
  input  wire logic                      mem_ready_in,
  // interrupts
  input  wire logic [3:0]                chan_irq_out
);
  logic       on_reg;
  logic [7:0] byte_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // enable seen
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      on_reg <= 1'b0;
    end else if (reg_write_in && reg_addr_in == fcdma_pkg::ADDR_GCTRL && reg_wdata_in[0]) begin
      on_reg <= 1'b1;
    end
  end
  // last byte read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_reg <= 8'h00;
    end else if (mem_req_out.read && mem_ready_in) begin
      byte_reg <= mem_rdata_in;
    end
  end
  excl_rw_a: assert property (!(mem_req_out.read && mem_req_out.write))
    else $error("read and write at once");
  read_hold_a: assert property (mem_req_out.read && !mem_ready_in && !$past(reg_write_in)
    |=> mem_req_out.read && $stable(mem_req_out.addr)) else $error("read dropped");
  write_hold_a: assert property (mem_req_out.write && !mem_ready_in && !$past(reg_write_in)
    |=> mem_req_out.write && $stable(mem_req_out.addr) && $stable(mem_req_out.wdata))
    else $error("write dropped");
  read_then_write_a: assert property (mem_req_out.read && mem_ready_in
    && !$past(reg_write_in) |=> mem_req_out.write) else $error("no write after read");
  copy_data_a: assert property (mem_req_out.write |-> mem_req_out.wdata == byte_reg)
    else $error("write data not the byte read");
  write_end_a: assert property (mem_req_out.write && mem_ready_in |=> !mem_req_out.write)
    else $error("write repeated");
  no_start_a: assert property (mem_req_out.read |-> on_reg)
    else $error("access before module enable");
  irq_sticky_a: assert property ((|($past(chan_irq_out) & ~chan_irq_out))
    |-> $past(reg_write_in)) else $error("irq fell without write");
  req_bit_a: assert property (reg_read_in && reg_addr_in[4:0] == 5'h10 && !reg_addr_in[7]
    |=> !reg_rdata_out[1]) else $error("request bit read back");
endmodule
bind fcdma_top fcdma_top_checker u_fcdma_top_checker (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in), .mem_ready_in(mem_ready_in),
  .chan_irq_out(chan_irq_out));

// File: tb/fcdma_mem_model.sv
`timescale 1ns/100ps
module fcdma_mem_model #(
  parameter int WAIT = 1
) (
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire fcdma_pkg::fcdma_mem_req_t req_in,
  output logic      [7:0]                rdata_out,
  output logic                           ready_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;
  int         wcnt_reg;
  int         n_rd;
  int         n_wr;
  // ready after WAIT stall cycles; idle data lines show the inverse of the last byte
  assign ready_out = (req_in.read || req_in.write) && wcnt_reg >= WAIT;
  assign rdata_out = req_in.read ? (req_in.addr[7:0] ^ 8'h5A) : ~last_reg;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wcnt_reg <= 0;
      n_rd <= 0;
      n_wr <= 0;
      last_reg <= 8'h00;
    end else if (ready_out) begin
      wcnt_reg <= 0;
      last_reg <= req_in.read ? rdata_out : req_in.wdata;
      if (req_in.read) n_rd <= n_rd + 1;
      if (req_in.write) begin
        mem[req_in.addr] <= req_in.wdata;
        n_wr <= n_wr + 1;
      end
    end else if (req_in.read || req_in.write) begin
      wcnt_reg <= wcnt_reg + 1;
    end
  end
endmodule

// File: tb/test_fcdma_top.sv
`timescale 1ns/100ps
module test_fcdma_top;
  logic                      clk_in = 1'b0;
  logic                      reset_n_in = 1'b0;
  logic [7:0]                reg_addr_in = 8'h00;
  logic [31:0]               reg_wdata_in = 32'h0;
  logic                      reg_write_in = 1'b0;
  logic                      reg_read_in = 1'b0;
  logic [31:0]               reg_rdata_out;
  logic [255:0]              periph_trig_in = '0;
  fcdma_pkg::fcdma_mem_req_t mem_req_out;
  logic [7:0]                mem_rdata_in;
  logic                      mem_ready_in;
  logic [3:0]                chan_irq_out;
  int                        num_errors = 0;
  int                        checked = 0;
  int                        base;
  always #4 clk_in = ~clk_in;
  fcdma_top u_fcdma_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .periph_trig_in(periph_trig_in), .mem_req_out(mem_req_out),
    .mem_rdata_in(mem_rdata_in), .mem_ready_in(mem_ready_in), .chan_irq_out(chan_irq_out));
  fcdma_mem_model #(.WAIT(1)) u_fcdma_mem_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .req_in(mem_req_out), .rdata_out(mem_rdata_in), .ready_out(mem_ready_in));
  task automatic final_report();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    reset_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic wait_flag(input int b);
    logic [31:0] d;
    for (int i = 0; i < 3000; i++) begin
      rd(fcdma_pkg::ADDR_INTSTAT, d);
      if (d[b] === 1'b1) return;
    end
    chk("complete flag wait", 32'h1, 32'h0);
  endtask
  function automatic logic [7:0] ca(input int n, input logic [7:0] ofs);
    return fcdma_pkg::ADDR_CH_BASE + fcdma_pkg::CH_STRIDE * 8'(n) + ofs;
  endfunction
  function automatic logic [31:0] cw(input logic [1:0] bl, input logic sgl, input logic ie);
    return 32'h1 | (32'(bl) << fcdma_pkg::CC_BL_LSB) | (32'(sgl) << fcdma_pkg::CC_SINGLE)
      | (32'(ie) << fcdma_pkg::CC_IE);
  endfunction
  task automatic cfg(input int n, input logic [7:0] ac, input logic [7:0] tg,
                     input logic [15:0] cnt, input logic [15:0] s, input logic [15:0] d);
    wr(ca(n, fcdma_pkg::OFS_ADDRCTL), {24'h0, ac});
    wr(ca(n, fcdma_pkg::OFS_TRIG), {24'h0, tg});
    wr(ca(n, fcdma_pkg::OFS_COUNT), {16'h0, cnt});
    wr(ca(n, fcdma_pkg::OFS_SRC), {16'h0, s});
    wr(ca(n, fcdma_pkg::OFS_DST), {16'h0, d});
  endtask
  task automatic start(input int n, input logic [31:0] c);
    wr(ca(n, fcdma_pkg::OFS_CTRL), c);
    wr(ca(n, fcdma_pkg::OFS_CTRL), c | 32'h2);
  endtask
  initial begin
    #(8 * 20000);
    num_errors++;
    final_report();
  end
  initial begin
    do_reset();
    rdchk("gctrl reset", fcdma_pkg::ADDR_GCTRL, 32'h0);
    rdchk("intstat reset", fcdma_pkg::ADDR_INTSTAT, 32'h0);
    // module off
    cfg(0, 8'h11, fcdma_pkg::TRIG_MANUAL, 16'h0004, 16'h1000, 16'h2000);
    start(0, cw(fcdma_pkg::BL_ONE, 1'b0, 1'b0));
    repeat (30) @(posedge clk_in);
    chk("reads with module off", 32'h0, 32'(u_fcdma_mem_model.n_rd));
    do_reset();
    wr(fcdma_pkg::ADDR_GCTRL, 32'h1);
    // request on a disabled channel
    wr(ca(3, fcdma_pkg::OFS_CTRL), 32'h2);
    repeat (30) @(posedge clk_in);
    chk("reads with channel off", 32'h0, 32'(u_fcdma_mem_model.n_rd));
    rdchk("ctrl request bit", ca(3, fcdma_pkg::OFS_CTRL), 32'h0);
    // eight-byte bursts, ten-byte block
    cfg(0, 8'h11, fcdma_pkg::TRIG_MANUAL, 16'h000A, 16'h1000, 16'h2000);
    start(0, cw(fcdma_pkg::BL_EIGHT, 1'b0, 1'b1));
    wait_flag(0);
    chk("irq after block", 32'h1, {28'h0, chan_irq_out});
    for (int k = 0; k < 10; k++) begin
      chk("copied byte", {24'h0, 8'(k) ^ 8'h5A}, {24'h0, u_fcdma_mem_model.mem[16'h2000 + k]});
    end
    chk("block bytes", 32'd10, 32'(u_fcdma_mem_model.n_wr));
    wr(fcdma_pkg::ADDR_INTSTAT, 32'h1);
    rdchk("flag cleared", fcdma_pkg::ADDR_INTSTAT, 32'h0);
    chk("irq cleared", 32'h0, {28'h0, chan_irq_out});
    // single shot, one byte per request, fixed destination
    cfg(2, 8'h01, fcdma_pkg::TRIG_MANUAL, 16'h0003, 16'h3000, 16'h4000);
    for (int k = 0; k < 3; k++) begin
      base = u_fcdma_mem_model.n_wr;
      start(2, cw(fcdma_pkg::BL_ONE, 1'b1, 1'b0));
      repeat (20) @(posedge clk_in);
      chk("bytes per request", 32'h1, 32'(u_fcdma_mem_model.n_wr - base));
      chk("fixed dest byte", {24'h0, 8'(k) ^ 8'h5A}, {24'h0, u_fcdma_mem_model.mem[16'h4000]});
    end
    rdchk("ch2 complete", fcdma_pkg::ADDR_INTSTAT, 32'h4);
    wr(fcdma_pkg::ADDR_INTSTAT, 32'h4);
    // peripheral trigger, reload per burst
    cfg(1, 8'h19, 8'h05, 16'h0008, 16'h5000, 16'h6000);
    wr(ca(1, fcdma_pkg::OFS_CTRL), cw(fcdma_pkg::BL_FOUR, 1'b1, 1'b0));
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_in);
      periph_trig_in[5] <= 1'b1;
      @(posedge clk_in);
      periph_trig_in[5] <= 1'b0;
      repeat (40) @(posedge clk_in);
    end
    for (int k = 0; k < 8; k++) begin
      chk("reloaded src byte", {24'h0, 8'(k % 4) ^ 8'h5A},
        {24'h0, u_fcdma_mem_model.mem[16'h6000 + k]});
    end
    rdchk("ch1 complete", fcdma_pkg::ADDR_INTSTAT, 32'h2);
    wr(fcdma_pkg::ADDR_INTSTAT, 32'h2);
    // disable mid transaction
    cfg(0, 8'h11, fcdma_pkg::TRIG_MANUAL, 16'h0064, 16'h1000, 16'h7000);
    start(0, cw(fcdma_pkg::BL_ONE, 1'b0, 1'b0));
    repeat (20) @(posedge clk_in);
    wr(ca(0, fcdma_pkg::OFS_CTRL), 32'h0);
    repeat (5) @(posedge clk_in);
    rdchk("abort error flag", fcdma_pkg::ADDR_INTSTAT, 32'h10);
    final_report();
  end
endmodule
